// ==== hw/irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;

   localparam int           NUM_SOURCES         = 15;
   localparam int           SRC_IDX_W           = 4;

   // special function register addresses
   localparam logic [7:0]   ADDR_ENABLE_PRIMARY = 8'ha8;
   localparam logic [7:0]   ADDR_PRIO_PRIMARY   = 8'hb8;
   localparam logic [7:0]   ADDR_ENABLE_TIMER2  = 8'he8;
   localparam logic [7:0]   ADDR_PRIO_TIMER2    = 8'hf8;
   localparam logic [7:0]   ADDR_FLAGS_PRIMARY  = 8'hc0;
   localparam logic [7:0]   ADDR_FLAGS_TIMER2   = 8'hc8;

   localparam logic [7:0]   REG_RESET           = 8'h00;
   localparam logic [7:0]   PRIO_PRIMARY_MASK   = 8'h7f;
   localparam int           GLOBAL_ENABLE_BIT   = 7;

   // primary flag register layout
   localparam int           FLAG_EXT0           = 0;
   localparam int           FLAG_TIMER0         = 1;
   localparam int           FLAG_EXT1           = 2;
   localparam int           FLAG_TIMER1         = 3;
   localparam int           FLAG_UART           = 4;
   localparam int           FLAG_TWO_WIRE       = 5;
   localparam int           FLAG_ADC_DONE       = 6;
   localparam int           FLAG_T2_BYTE_OVF    = 7;

   // timer2 flag register layout
   localparam int           FLAG_CAPTURE_BASE   = 0;
   localparam int           FLAG_COMPARE_BASE   = 4;
   localparam int           FLAG_T2_WORD_OVF    = 7;
   localparam int           NUM_CAPTURE         = 4;
   localparam int           NUM_COMPARE         = 3;

   // source index = vector order
   localparam logic [3:0]   SRC_EXT0            = 4'h0;
   localparam logic [3:0]   SRC_TIMER0          = 4'h1;
   localparam logic [3:0]   SRC_EXT1            = 4'h2;
   localparam logic [3:0]   SRC_TIMER1          = 4'h3;

   localparam logic [15:0]  VECTOR_BASE         = 16'h0003;
   localparam logic [15:0]  VECTOR_STEP         = 16'h0008;

   localparam logic [7:0]   BYTE_MAX            = 8'hff;
   localparam logic [15:0]  WORD_MAX            = 16'hffff;

   // polling order within a level, highest first, as source indices
   localparam logic [3:0]   POLL_ORDER [NUM_SOURCES] = '{
      4'h0, 4'h5, 4'ha, 4'h1, 4'h6, 4'hb, 4'h2, 4'h7,
      4'hc, 4'h3, 4'h8, 4'hd, 4'h4, 4'h9, 4'he};

   typedef enum logic [1:0] {
      INH_IDLE  = 2'b00,
      INH_ARMED = 2'b01,
      INH_WAIT  = 2'b11
   } inhibit_state_t;

endpackage : irq_ctrl_pkg

// ==== hw/two_level_interrupt_controller.sv ====
// Operation
// [RL1] fifteen sources, each assignable to low or high level
// [RL2] eight timer2 requests: four captures, three compares, one ORed overflow
// [RL3] capture flag set by capture input; compare flag set on timer2 equal compare
// [RL4] byte overflow sets byte flag; word overflow sets word flag
// [RL5] nine timer2 flags never cleared by hardware
// [RL6] adc done flag set on result ready, requests adc, no hardware clear
// [RL7] software may clear adc done flag; writing one does nothing
// [RL8] two-wire request from event flag set on valid status load
// [RL9] other flags software writable both ways, same as hardware; level-mode external flags follow the pin and ignore writes
// [RL10] per-source enable bits; global enable bit 7 low blocks all
// [RL11] primary enable layout: global, adc, two-wire, uart, t1, ext1, t0, ext0
// [RL12] timer2 enable layout: overflow, compare 2..0, capture 3..0
// [RL13] priority bit zero low level, one high level
// [RL14] high preempts low routine; nothing preempts high routine
// [RL15] high level wins simultaneous; same level uses fixed polling order
// [RL16] polling order only for simultaneous requests, never preempts
// [RL17] flags sampled at sample point, polled next machine cycle
// [RL18] no vector while equal or higher active, or before final cycle
// [RL19] after return or enable/priority access, wait one more instruction
// [RL20] blocked requests are not remembered
// [RL21] ack clears timer0/timer1 flags, external flag only if edge mode
// [RL22] ack issues long call with vector and sets level active flop
// [RL23] return clears the active level flop
// [RL24] within-level polling order as listed, external 0 highest
// [RL25] vectors from 0003h stepping by eight in source order
// [RL26] primary priority layout bits 6..0, bit 7 unused
// [RL27] timer2 priority layout: overflow, compare 2..0, capture 3..0
`timescale 1ns/1ps
`default_nettype none

module two_level_interrupt_controller (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic [7:0]          sfr_addr,
   input  wire logic                sfr_wr,
   input  wire logic                sfr_rd,
   input  wire logic [7:0]          sfr_wdata,
   output var  logic [7:0]          sfr_rdata,
   input  wire logic                sample_phase_point,
   input  wire logic                instr_last_cycle,
   input  wire logic                instr_done,
   input  wire logic                reti_exec,
   input  wire logic [1:0]          external_request_pin_n,
   input  wire logic [1:0]          ext_edge_mode,
   input  wire logic                timer0_ovf_evt,
   input  wire logic                timer1_ovf_evt,
   input  wire logic                uart_port_evt,
   input  wire logic                two_wire_status_load,
   input  wire logic                adc_result_ready,
   input  wire logic [3:0]          capture_input_signals,
   input  wire logic [15:0]         timer2_count,
   input  wire logic [2:0][15:0]    compare_register,
   output var  logic                call_req,
   output var  logic [15:0]         call_vector,
   output var  logic                call_level,
   output var  logic                active_hi,
   output var  logic                active_lo
);
   import irq_ctrl_pkg::*;

   logic [7:0]             interrupt_enable_primary_q;
   logic [7:0]             interrupt_enable_timer2_q;
   logic [7:0]             ip0_q;
   logic [7:0]             ip1_q;
   logic [7:0]             pflag_q;
   logic [7:0]             pflag_d;
   logic [7:0]             tflag_q;
   logic [7:0]             tflag_d;
   logic [15:0]            count_prev_q;
   logic [1:0]             ext_prev_n_q;
   logic [NUM_SOURCES-1:0] samples_q;
   logic [NUM_SOURCES-1:0] req;
   logic [NUM_SOURCES-1:0] en;
   logic [NUM_SOURCES-1:0] prio;
   logic [NUM_SOURCES-1:0] hi_cand;
   logic [NUM_SOURCES-1:0] lo_cand;
   logic [7:0]             pset;
   logic [7:0]             pclr;
   logic [7:0]             tset;
   logic                   wr_pflag;
   logic                   wr_tflag;
   logic                   irq_reg_access;
   logic                   hi_found;
   logic                   lo_found;
   logic [3:0]             hi_idx;
   logic [3:0]             lo_idx;
   logic                   take;
   logic                   take_hi;
   logic [3:0]             win_idx;
   inhibit_state_t         inh_q;
   inhibit_state_t         inh_d;
   logic                   byte_ovf;
   logic                   word_ovf;
   logic                   count_moved;

   assign wr_pflag       = sfr_wr && (sfr_addr == ADDR_FLAGS_PRIMARY);
   assign wr_tflag       = sfr_wr && (sfr_addr == ADDR_FLAGS_TIMER2);
   assign irq_reg_access = (sfr_wr || sfr_rd) &&
                           ((sfr_addr == ADDR_ENABLE_PRIMARY) || (sfr_addr == ADDR_PRIO_PRIMARY) ||
                            (sfr_addr == ADDR_ENABLE_TIMER2)  || (sfr_addr == ADDR_PRIO_TIMER2));

   // overflow seen as the count wrapping between consecutive cycles
   assign count_moved = (timer2_count != count_prev_q);
   assign byte_ovf    = (count_prev_q[7:0] == BYTE_MAX) && (timer2_count[7:0] == 8'h00);  // [RL4]
   assign word_ovf    = (count_prev_q == WORD_MAX) && (timer2_count == 16'h0000);         // [RL4]

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_prev_q <= 16'h0000;
         ext_prev_n_q <= 2'b11;
      end else begin
         count_prev_q <= timer2_count;
         ext_prev_n_q <= external_request_pin_n;
      end
   end

   // hardware set and clear terms
   always_comb begin
      pset = 8'h00;
      pclr = 8'h00;
      tset = 8'h00;
      pset[FLAG_EXT0]        = ext_prev_n_q[0] && !external_request_pin_n[0];
      pset[FLAG_EXT1]        = ext_prev_n_q[1] && !external_request_pin_n[1];
      pset[FLAG_TIMER0]      = timer0_ovf_evt;
      pset[FLAG_TIMER1]      = timer1_ovf_evt;
      pset[FLAG_UART]        = uart_port_evt;
      pset[FLAG_TWO_WIRE]    = two_wire_status_load;                          // [RL8]
      pset[FLAG_ADC_DONE]    = adc_result_ready;                              // [RL6]
      pset[FLAG_T2_BYTE_OVF] = byte_ovf;                                      // [RL4]
      pclr[FLAG_TIMER0]      = take && (win_idx == SRC_TIMER0);               // [RL21]
      pclr[FLAG_TIMER1]      = take && (win_idx == SRC_TIMER1);               // [RL21]
      pclr[FLAG_EXT0]        = take && (win_idx == SRC_EXT0) && ext_edge_mode[0]; // [RL21]
      pclr[FLAG_EXT1]        = take && (win_idx == SRC_EXT1) && ext_edge_mode[1]; // [RL21]
      for (int c = 0; c < NUM_CAPTURE; c++) begin
         tset[FLAG_CAPTURE_BASE+c] = capture_input_signals[c];                // [RL3]
      end
      for (int m = 0; m < NUM_COMPARE; m++) begin
         tset[FLAG_COMPARE_BASE+m] = count_moved && (timer2_count == compare_register[m]); // [RL3]
      end
      tset[FLAG_T2_WORD_OVF] = word_ovf;                                      // [RL4]
   end

   // per-bit flag next state; a set always wins over any clear
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_flag
         if (b == FLAG_ADC_DONE) begin : g_adc
            // software can only clear this one
            assign pflag_d[b] = pset[b] | (wr_pflag ? (pflag_q[b] & sfr_wdata[b]) : pflag_q[b]); // [RL7]
         end else if (b == FLAG_EXT0 || b == FLAG_EXT1) begin : g_ext
            localparam int X = (b == FLAG_EXT0) ? 0 : 1;
            // level mode tracks the pin, so writes have no effect
            assign pflag_d[b] = ext_edge_mode[X] ?
                                (pset[b] | (~pclr[b] & (wr_pflag ? sfr_wdata[b] : pflag_q[b]))) :
                                !external_request_pin_n[X];                   // [RL9]
         end else begin : g_plain
            assign pflag_d[b] = pset[b] | (~pclr[b] & (wr_pflag ? sfr_wdata[b] : pflag_q[b])); // [RL9]
         end
         // timer2 flags: no hardware clear at all
         assign tflag_d[b] = tset[b] | (wr_tflag ? sfr_wdata[b] : tflag_q[b]);  // [RL5] [RL9]
      end
   endgenerate

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pflag_q <= REG_RESET;
         tflag_q <= REG_RESET;
      end else begin
         pflag_q <= pflag_d;
         tflag_q <= tflag_d;
      end
   end

   // enable and priority registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         interrupt_enable_primary_q <= REG_RESET;
         interrupt_enable_timer2_q <= REG_RESET;
         ip0_q  <= REG_RESET;
         ip1_q  <= REG_RESET;
      end else if (sfr_wr) begin
         if (sfr_addr == ADDR_ENABLE_PRIMARY) begin
            interrupt_enable_primary_q <= sfr_wdata;                                              // [RL11]
         end
         if (sfr_addr == ADDR_ENABLE_TIMER2) begin
            interrupt_enable_timer2_q <= sfr_wdata;                                              // [RL12]
         end
         if (sfr_addr == ADDR_PRIO_PRIMARY) begin
            ip0_q <= sfr_wdata & PRIO_PRIMARY_MASK;                           // [RL26]
         end
         if (sfr_addr == ADDR_PRIO_TIMER2) begin
            ip1_q <= sfr_wdata;                                               // [RL27]
         end
      end
   end

   // source vectors in vector order
   assign req  = {tflag_q[FLAG_T2_WORD_OVF] | pflag_q[FLAG_T2_BYTE_OVF],      // [RL2]
                  tflag_q[FLAG_COMPARE_BASE +: NUM_COMPARE],
                  pflag_q[FLAG_ADC_DONE],
                  tflag_q[FLAG_CAPTURE_BASE +: NUM_CAPTURE],
                  pflag_q[FLAG_TWO_WIRE:FLAG_EXT0]};                          // [RL1]
   assign en   = {interrupt_enable_timer2_q[7:4], interrupt_enable_primary_q[6], interrupt_enable_timer2_q[3:0], interrupt_enable_primary_q[5:0]};          // [RL10] [RL11] [RL12]
   assign prio = {ip1_q[7:4], ip0_q[6], ip1_q[3:0], ip0_q[5:0]};              // [RL13] [RL26] [RL27]

   // sampling at the phase point; old samples are simply overwritten
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         samples_q <= '0;
      end else if (sample_phase_point) begin
         samples_q <= req & en & {NUM_SOURCES{interrupt_enable_primary_q[GLOBAL_ENABLE_BIT]}};    // [RL10] [RL17] [RL20]
      end
   end

   assign hi_cand = samples_q & prio;                                         // [RL13]
   assign lo_cand = samples_q & ~prio;

   // scanned lowest first so the highest in polling order overwrites
   always_comb begin
      hi_found = 1'b0;
      lo_found = 1'b0;
      hi_idx   = 4'h0;
      lo_idx   = 4'h0;
      for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
         if (hi_cand[POLL_ORDER[i]]) begin
            hi_found = 1'b1;
            hi_idx   = POLL_ORDER[i];                                         // [RL24]
         end
         if (lo_cand[POLL_ORDER[i]]) begin
            lo_found = 1'b1;
            lo_idx   = POLL_ORDER[i];                                         // [RL24]
         end
      end
   end

   // one more whole instruction must pass after a return or an enable/priority register access
   always_comb begin
      inh_d = inh_q;
      case (inh_q)
         INH_IDLE: begin
            if (irq_reg_access || reti_exec) begin
               inh_d = instr_done ? INH_WAIT : INH_ARMED;                     // [RL19]
            end
         end
         INH_ARMED: begin
            if (instr_done) begin
               inh_d = INH_WAIT;                                              // [RL19]
            end
         end
         INH_WAIT: begin
            if (irq_reg_access || reti_exec) begin
               inh_d = instr_done ? INH_WAIT : INH_ARMED;
            end else if (instr_done) begin
               inh_d = INH_IDLE;                                              // [RL19]
            end
         end
         default: inh_d = INH_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         inh_q <= INH_IDLE;
      end else begin
         inh_q <= inh_d;
      end
   end

   // high wins if allowed; a running high routine blocks everything
   assign take_hi = hi_found && !active_hi;                                   // [RL14] [RL15]
   assign take    = sample_phase_point && instr_last_cycle &&                 // [RL17] [RL18]
                    (inh_q == INH_IDLE) && !irq_reg_access && !reti_exec &&   // [RL19]
                    (take_hi || (lo_found && !active_hi && !active_lo));      // [RL16] [RL18]
   assign win_idx = take_hi ? hi_idx : lo_idx;                                // [RL15]

   // call request and vector
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         call_req    <= 1'b0;
         call_vector <= 16'h0000;
         call_level  <= 1'b0;
      end else begin
         call_req <= take;                                                    // [RL22]
         if (take) begin
            call_vector <= VECTOR_BASE + VECTOR_STEP * {12'h000, win_idx};    // [RL25]
            call_level  <= take_hi;
         end
      end
   end

   // level active flip-flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         active_hi <= 1'b0;
         active_lo <= 1'b0;
      end else if (take) begin
         if (take_hi) begin
            active_hi <= 1'b1;                                                // [RL22]
         end else begin
            active_lo <= 1'b1;                                                // [RL22]
         end
      end else if (reti_exec) begin
         if (active_hi) begin
            active_hi <= 1'b0;                                                // [RL23]
         end else begin
            active_lo <= 1'b0;                                                // [RL23]
         end
      end
   end

   // readback, one cycle after the read strobe; unmapped reads zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            ADDR_ENABLE_PRIMARY: sfr_rdata <= interrupt_enable_primary_q;
            ADDR_ENABLE_TIMER2:  sfr_rdata <= interrupt_enable_timer2_q;
            ADDR_PRIO_PRIMARY:   sfr_rdata <= ip0_q;
            ADDR_PRIO_TIMER2:    sfr_rdata <= ip1_q;
            ADDR_FLAGS_PRIMARY:  sfr_rdata <= pflag_q;
            ADDR_FLAGS_TIMER2:   sfr_rdata <= tflag_q;
            default:             sfr_rdata <= 8'h00;
         endcase
      end
   end

endmodule : two_level_interrupt_controller

`default_nettype wire

// ==== sim/irq_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_monitor
   import irq_ctrl_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_wr,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        sample_phase_point,
   input wire logic        instr_last_cycle,
   input wire logic        reti_exec,
   input wire logic        call_req,
   input wire logic [15:0] call_vector,
   input wire logic        call_level,
   input wire logic        active_hi,
   input wire logic        active_lo
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_call_cause: assert property (call_req |-> $past(sample_phase_point) && $past(instr_last_cycle))
      else $error("call outside a final-cycle poll");
   a_vector_form: assert property (call_req |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h0073)
      else $error("vector outside table");
   a_level_set: assert property (call_req |-> (call_level ? active_hi : active_lo))
      else $error("active flop not set");
   a_hi_no_preempt: assert property (call_req |-> !$past(active_hi))
      else $error("call while high level active");
   a_lo_blocked: assert property (call_req && !call_level |-> !$past(active_lo))
      else $error("low call while low level active");
   a_ret_clears: assert property (reti_exec |=> ($past(active_hi) ? !active_hi : !active_lo))
      else $error("return left level active");
   a_ret_holdoff: assert property (reti_exec |=> !call_req [*3])
      else $error("call too soon after return");
   a_access_holdoff: assert property ((sfr_wr || sfr_rd) && sfr_addr inside {8'ha8, 8'hb8, 8'he8, 8'hf8}
      |=> !call_req [*3]) else $error("call too soon after access");
   a_prio_top_bit: assert property (sfr_rd && sfr_addr == ADDR_PRIO_PRIMARY |=> !sfr_rdata[7])
      else $error("unused priority bit read as one");
endmodule : irq_ctrl_monitor
`default_nettype wire

// ==== sim/core_seq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic slow,
   input  wire logic ret_req,
   output var  logic sample_phase_point,
   output var  logic instr_last_cycle,
   output var  logic instr_done,
   output var  logic reti_exec
);
   logic [1:0] phase_q;
   logic       first_q;
   logic       ret_pend_q;
   // four clocks a machine cycle; slow gives two-cycle instructions
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_q <= 2'h0;
         first_q <= 1'b0;
      end else begin
         phase_q <= phase_q + 2'h1;
         if (phase_q == 2'h3) first_q <= slow && !first_q;
      end
   end
   // return runs as the next instruction to finish
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) ret_pend_q <= 1'b0;
      else if (ret_req) ret_pend_q <= 1'b1;
      else if (reti_exec) ret_pend_q <= 1'b0;
   end
   assign sample_phase_point = (phase_q == 2'h2);
   assign instr_last_cycle   = !first_q;
   assign instr_done         = (phase_q == 2'h3) && !first_q;
   assign reti_exec          = instr_done && ret_pend_q;
endmodule : core_seq_model
`default_nettype wire

// ==== sim/two_level_interrupt_controller_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_controller_tb;
   import irq_ctrl_pkg::*;
   typedef struct packed {logic [7:0] a; logic [2:0] b; logic hc; logic [15:0] v;} row_t;
   logic             clk, reset_n, sfr_wr, sfr_rd, sample_phase_point, instr_last_cycle, instr_done, reti_exec;
   logic             timer0_ovf_evt, timer1_ovf_evt, uart_port_evt, two_wire_status_load, adc_result_ready;
   logic             call_req, call_level, active_hi, active_lo, slow, ret_req;
   logic [7:0]       sfr_addr, sfr_wdata, sfr_rdata;
   logic [1:0]       external_request_pin_n, ext_edge_mode;
   logic [3:0]       capture_input_signals;
   logic [15:0]      timer2_count, call_vector;
   logic [2:0][15:0] compare_register;
   int               error_cnt, check_count, cycles;
   // enable reg, bit (same in flag reg), cleared on ack, vector
   row_t rows [15] = '{'{8'ha8, 3'h0, 1'b1, 16'h0003}, '{8'ha8, 3'h1, 1'b1, 16'h000b}, '{8'ha8, 3'h2, 1'b1, 16'h0013},
      '{8'ha8, 3'h3, 1'b1, 16'h001b}, '{8'ha8, 3'h4, 1'b0, 16'h0023}, '{8'ha8, 3'h5, 1'b0, 16'h002b},
      '{8'he8, 3'h0, 1'b0, 16'h0033}, '{8'he8, 3'h1, 1'b0, 16'h003b}, '{8'he8, 3'h2, 1'b0, 16'h0043},
      '{8'he8, 3'h3, 1'b0, 16'h004b}, '{8'ha8, 3'h6, 1'b0, 16'h0053}, '{8'he8, 3'h4, 1'b0, 16'h005b},
      '{8'he8, 3'h5, 1'b0, 16'h0063}, '{8'he8, 3'h6, 1'b0, 16'h006b}, '{8'he8, 3'h7, 1'b0, 16'h0073}};
   logic [7:0] regs [7] = '{8'ha8, 8'hb8, 8'he8, 8'hf8, 8'hc0, 8'hc8, 8'h55};

   two_level_interrupt_controller uut (.*);
   core_seq_model core (.*);

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      {sfr_addr, sfr_rd} = {a, 1'b1};
      @(negedge clk);
      sfr_rd = 1'b0;
      d = sfr_rdata;
   endtask : rd
   function automatic logic [7:0] flag_of(input logic [7:0] a);
      return (a == ADDR_ENABLE_PRIMARY) ? ADDR_FLAGS_PRIMARY : ADDR_FLAGS_TIMER2;
   endfunction : flag_of
   task automatic wait_call(input logic [15:0] v, input logic lvl);
      int n;
      n = 0;
      while (call_req !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk(call_req, 16'h0001);
      chk({call_vector, call_level}, {v, lvl});
      chk(lvl ? active_hi : active_lo, 16'h0001);
   endtask : wait_call
   task automatic quiet(input int n);
      int s;
      s = 0;
      repeat (n) begin
         @(negedge clk);
         if (call_req !== 1'b0) s++;
      end
      chk(s[15:0], 16'h0000);
   endtask : quiet
   task automatic do_ret;
      int n;
      n = 0;
      @(negedge clk);
      ret_req = 1'b1;
      @(negedge clk);
      ret_req = 1'b0;
      while (reti_exec !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      chk(reti_exec, 16'h0001);
      @(negedge clk);
   endtask : do_ret
   task automatic fire(input int k);
      @(negedge clk);
      case (k)
         0, 2: external_request_pin_n[k/2] = 1'b0;
         1: timer0_ovf_evt = 1'b1;
         3: timer1_ovf_evt = 1'b1;
         4: uart_port_evt = 1'b1;
         5: two_wire_status_load = 1'b1;
         10: adc_result_ready = 1'b1;
         11, 12, 13: timer2_count = compare_register[k-11];
         14: timer2_count = WORD_MAX;
         default: capture_input_signals[k-6] = 1'b1;
      endcase
      @(negedge clk);
      {timer0_ovf_evt, timer1_ovf_evt, uart_port_evt, two_wire_status_load, adc_result_ready} = 5'h00;
      {external_request_pin_n, capture_input_signals} = 6'h30;
      if (k == 14) timer2_count = 16'h0000;
   endtask : fire
   task automatic report_and_stop;
      if (error_cnt == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // generous ceiling; the run needs under two thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         error_cnt++;
         $display("[FAIL] %0t run hung", $time);
         report_and_stop();
      end
   end

   initial begin
      logic [7:0] d;
      logic [3:0] k;
      {reset_n, sfr_wr, sfr_rd, slow, ret_req, sfr_addr, sfr_wdata, timer2_count} = '0;
      {timer0_ovf_evt, timer1_ovf_evt, uart_port_evt, two_wire_status_load, adc_result_ready} = 5'h00;
      {external_request_pin_n, ext_edge_mode, capture_input_signals} = 8'hf0;
      compare_register = {16'h1403, 16'h1302, 16'h1201};
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(regs[i], d);
         chk(d, 16'h0000);
      end
      wr(ADDR_PRIO_PRIMARY, 8'hff);
      rd(ADDR_PRIO_PRIMARY, d);
      chk(d, 16'h007f);
      wr(ADDR_PRIO_TIMER2, 8'hff);
      rd(ADDR_PRIO_TIMER2, d);
      chk(d, 16'h00ff);
      wr(ADDR_PRIO_TIMER2, 8'h00);
      wr(ADDR_PRIO_PRIMARY, 8'h00);
      wr(ADDR_FLAGS_PRIMARY, 8'h40);
      rd(ADDR_FLAGS_PRIMARY, d);
      chk(d, 16'h0000);
      // one source enabled at a time, hardware event, low level
      for (int i = 0; i < 15; i++) begin
         slow = i[0];
         wr(ADDR_ENABLE_PRIMARY, 8'h80 | ((rows[i].a == 8'ha8) ? (8'h01 << rows[i].b) : 8'h00));
         wr(ADDR_ENABLE_TIMER2, (rows[i].a == 8'he8) ? (8'h01 << rows[i].b) : 8'h00);
         fire(i);
         wait_call(rows[i].v, 1'b0);
         rd(flag_of(rows[i].a), d);
         chk(d[rows[i].b], !rows[i].hc);
         wr(flag_of(rows[i].a), 8'h00);
         if (i == 14) wr(ADDR_FLAGS_PRIMARY, 8'h00);
         do_ret;
         chk(active_lo, 16'h0000);
      end
      // all fifteen pending at once, drained in polling order
      wr(ADDR_ENABLE_PRIMARY, 8'h00);
      wr(ADDR_FLAGS_PRIMARY, 8'hbf);
      wr(ADDR_FLAGS_TIMER2, 8'hff);
      fire(10);
      wr(ADDR_ENABLE_TIMER2, 8'hff);
      wr(ADDR_ENABLE_PRIMARY, 8'hff);
      for (int j = 0; j < 15; j++) begin
         k = POLL_ORDER[j];
         wait_call(16'h0003 + {9'h000, k, 3'h0}, 1'b0);
         rd(flag_of(rows[k].a), d);
         if (!rows[k].hc) wr(flag_of(rows[k].a), d & ~(8'h01 << rows[k].b));
         if (k == 4'he) wr(ADDR_FLAGS_PRIMARY, 8'h00);
         do_ret;
      end
      // global enable off, then a request that vanished while blocked
      wr(ADDR_ENABLE_PRIMARY, 8'h7f);
      wr(ADDR_FLAGS_PRIMARY, 8'h02);
      quiet(40);
      wr(ADDR_FLAGS_PRIMARY, 8'h00);
      wr(ADDR_ENABLE_PRIMARY, 8'hff);
      quiet(40);
      // uart high level: preempts low, is not preempted
      wr(ADDR_PRIO_PRIMARY, 8'h10);
      wr(ADDR_FLAGS_PRIMARY, 8'h01);
      wait_call(16'h0003, 1'b0);
      wr(ADDR_FLAGS_PRIMARY, 8'h10);
      wait_call(16'h0023, 1'b1);
      wr(ADDR_FLAGS_PRIMARY, 8'h01);
      quiet(40);
      do_ret;
      chk({active_hi, active_lo}, 16'h0001);
      quiet(40);
      do_ret;
      wait_call(16'h0003, 1'b0);
      wr(ADDR_FLAGS_PRIMARY, 8'h00);
      do_ret;
      wr(ADDR_ENABLE_PRIMARY, 8'h00);
      wr(ADDR_FLAGS_PRIMARY, 8'h11);
      wr(ADDR_ENABLE_PRIMARY, 8'hff);
      wait_call(16'h0023, 1'b1);
      wr(ADDR_FLAGS_PRIMARY, 8'h00);
      do_ret;
      // level-triggered external 1: flag follows the pin, ack leaves it
      @(negedge clk);
      {ext_edge_mode, external_request_pin_n} = 4'b0101;
      wait_call(16'h0013, 1'b0);
      rd(ADDR_FLAGS_PRIMARY, d);
      chk(d, 16'h0004);
      // reset in mid-routine clears outputs and registers
      reset_n = 1'b0;
      external_request_pin_n = 2'b11;
      repeat (2) @(negedge clk);
      chk(call_vector, 16'h0000);
      chk({call_req, call_level, active_hi, active_lo}, 16'h0000);
      reset_n = 1'b1;
      rd(ADDR_ENABLE_PRIMARY, d);
      chk(d, 16'h0000);
      report_and_stop();
   end
endmodule : two_level_interrupt_controller_tb
bind two_level_interrupt_controller irq_ctrl_monitor mon (.*);
`default_nettype wire
